// File: src/rba_pkg.sv
// register bit access package: offsets, reset values, decode helper
// assumes one register bank per block, word-wide access on a plain port
package rba_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int DW = 8;        // register width
    localparam int AW = 4;        // address width, 16 slots

    // ------------------------------------------------------------
    // register offsets (word index)
    // ------------------------------------------------------------
    localparam logic [AW-1:0] OFF_CONFIG = 4'h0;  // plain read/write
    localparam logic [AW-1:0] OFF_KEEP = 4'h1;    // soft_reset_immune
    localparam logic [AW-1:0] OFF_STATUS = 4'h2;  // read-only live status
    localparam logic [AW-1:0] OFF_SOR = 4'h3;     // set_on_read
    localparam logic [AW-1:0] OFF_CMD = 4'h4;     // write-only
    localparam logic [AW-1:0] OFF_W1S = 4'h5;     // write one to set
    localparam logic [AW-1:0] OFF_W1C = 4'h6;     // write one to clear
    localparam logic [AW-1:0] OFF_WAC = 4'h7;     // write_any_clear
    localparam logic [AW-1:0] OFF_LLO = 4'h8;     // latch_low_clear_on_read
    localparam logic [AW-1:0] OFF_LHI = 4'h9;     // latch_high_clear_on_read
    localparam logic [AW-1:0] OFF_SCL = 4'hA;     // self_clearing
    localparam logic [AW-1:0] OFF_STK = 4'hB;     // sticky_high_status

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DW-1:0] RST_CONFIG = 8'h00;
    localparam logic [DW-1:0] RST_KEEP = 8'h00;
    localparam logic [DW-1:0] RST_SOR = 8'h00;
    localparam logic [DW-1:0] RST_CMD = 8'h00;
    localparam logic [DW-1:0] RST_W1S = 8'h00;
    localparam logic [DW-1:0] RST_EVT = 8'h00;
    localparam logic [DW-1:0] RD_UNMAPPED = 8'h00;  // reserved/write-only reads

    // address hit helper, used for every register strobe
    function automatic logic rba_hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
        rba_hit = (a == off);
    endfunction : rba_hit

endpackage : rba_pkg

// File: src/rba_latch.sv
// latching status cell: holds a low or high event until read
// assumes rd_clr_i is a one-cycle pulse per completed read
`timescale 1ns/1ps
module rba_latch #(
    parameter int W = rba_pkg::DW,
    parameter bit HIGH = 1'b1     // 1: latch high, 0: latch low
) (
    input wire logic clock_i,
    input wire logic rst_i,        // power-on and soft reset combined
    input wire logic [W-1:0] src_i,  // live condition
    input wire logic rd_clr_i,     // read of the owning register
    output logic [W-1:0] val_o     // readable value
);
    import rba_pkg::*;

    logic [W-1:0] hit_r;           // event seen since last read
    logic [W-1:0] act;             // condition active this cycle

    assign act = HIGH ? src_i : ~src_i;

    // ------------------------------------------------------------
    // latch: new event beats the read clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            hit_r <= '0;
        end
        else
        begin
            hit_r <= (hit_r & {W{~rd_clr_i}}) | act;
        end
    end

    // latched event forces the active level until the read
    assign val_o = HIGH ? (src_i | hit_r) : (src_i & ~hit_r);

endmodule : rba_latch

// File: src/rba_sticky.sv
// sticky high status: stays up until read, falls once cause is gone
// assumes rd_i is a one-cycle pulse per completed read
`timescale 1ns/1ps
module rba_sticky #(
    parameter int W = rba_pkg::DW
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [W-1:0] cond_i,  // causing condition
    input wire logic rd_i,            // read of the owning register
    output logic [W-1:0] val_o
);
    import rba_pkg::*;

    logic [W-1:0] st_r;       // status bits
    logic [W-1:0] armed_r;    // read seen while high
    logic [W-1:0] st_nxt;

    // read releases the hold; the live cause keeps the bit up
    assign st_nxt = cond_i | (st_r & ~(armed_r | {W{rd_i}}));

    // ------------------------------------------------------------
    // status and release tracking
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
            armed_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            // a fresh rise needs a fresh read before it may fall
            armed_r <= st_r & st_nxt & (armed_r | {W{rd_i}});
        end
    end

    assign val_o = st_r;

endmodule : rba_sticky

// File: src/rba_bank.sv
// register bank showing each bit access attribute
// assumes a single-cycle rd_i or wr_i strobe per access, synchronous inputs
//
// Notes on behaviour
// - read-only bits read live, ignore writes
// - set_on_read bits become one after read
// - write-only register accepts writes, reads return zero
// - write one sets, zero leaves unchanged
// - write one clears, zero leaves unchanged
// - any write clears write_any_clear bits
// - latch bits hold until register read clears
// - self_clearing bits drop alone, zero ignored
// - sticky status held until read, then follows
// - soft reset spares soft_reset_immune bits only
// - reserved bits read zero, software ignores
`timescale 1ns/1ps
module rba_bank #(
    parameter int W = rba_pkg::DW
) (
    input wire logic clock_i,
    input wire logic rst_i,                   // power-on reset, sync, high
    input wire logic soft_rst_i,              // software reset, sync, high
    input wire logic [rba_pkg::AW-1:0] addr_i,
    input wire logic wr_i,                    // write strobe, one cycle
    input wire logic rd_i,                    // read strobe, one cycle
    input wire logic [W-1:0] wdata_i,
    output logic [W-1:0] rdata_o,             // registered read data
    output logic rvalid_o,                    // read data valid pulse
    input wire logic [W-1:0] status_i,        // read-only source
    input wire logic [W-1:0] w1s_done_i,      // hardware clear of set bits
    input wire logic [W-1:0] evt_w1c_i,       // events into write-one-clear
    input wire logic [W-1:0] evt_wac_i,       // events into write_any_clear
    input wire logic [W-1:0] ll_src_i,        // latch_low_clear_on_read source
    input wire logic [W-1:0] lh_src_i,        // latch_high_clear_on_read source
    input wire logic [W-1:0] cond_i,          // sticky_high_status cause
    output logic [W-1:0] config_o,
    output logic [W-1:0] keep_o,
    output logic [W-1:0] sor_o,
    output logic [W-1:0] cmd_o,
    output logic [W-1:0] w1s_o,
    output logic [W-1:0] w1c_o,
    output logic [W-1:0] wac_o,
    output logic [W-1:0] sc_o
);
    import rba_pkg::*;

    // ------------------------------------------------------------
    // access strobes
    // ------------------------------------------------------------
    logic wr_go;        // write wins a clash with read
    logic rd_go;        // completed read, never on a write cycle
    logic sreset;       // either reset, for non-immune bits
    logic [W-1:0] config_r;
    logic [W-1:0] keep_r;
    logic [W-1:0] sor_r;
    logic [W-1:0] cmd_r;
    logic [W-1:0] w1s_r;
    logic [W-1:0] w1c_r;
    logic [W-1:0] wac_r;
    logic [W-1:0] sc_r;
    logic [W-1:0] ll_val;
    logic [W-1:0] lh_val;
    logic [W-1:0] stk_val;
    logic [W-1:0] rd_nxt;
    logic [W-1:0] rdata_r;
    logic rvalid_r;

    assign wr_go = wr_i;
    assign rd_go = rd_i & ~wr_i;
    assign sreset = rst_i | soft_rst_i;

    // ------------------------------------------------------------
    // plain config, cleared by either reset
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (sreset)
        begin
            config_r <= RST_CONFIG;
        end
        else if (wr_go && rba_hit(addr_i, OFF_CONFIG))
        begin
            config_r <= wdata_i;
        end
    end

    // ------------------------------------------------------------
    // immune register: only power-on reset touches it
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            keep_r <= RST_KEEP;
        end
        else if (wr_go && rba_hit(addr_i, OFF_KEEP))
        begin
            keep_r <= wdata_i;                   // soft reset ignored
        end
    end

    // ------------------------------------------------------------
    // set_on_read: read returns old value, then all ones
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (sreset)
        begin
            sor_r <= RST_SOR;
        end
        else if (wr_go && rba_hit(addr_i, OFF_SOR))
        begin
            sor_r <= wdata_i;
        end
        else if (rd_go && rba_hit(addr_i, OFF_SOR))
        begin
            sor_r <= '1;
        end
    end

    // ------------------------------------------------------------
    // write-only command word
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (sreset)
        begin
            cmd_r <= RST_CMD;
        end
        else if (wr_go && rba_hit(addr_i, OFF_CMD))
        begin
            cmd_r <= wdata_i;
        end
    end

    // ------------------------------------------------------------
    // write one to set; hardware done clears, software set wins
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (sreset)
        begin
            w1s_r <= RST_W1S;
        end
        else if (wr_go && rba_hit(addr_i, OFF_W1S))
        begin
            w1s_r <= (w1s_r & ~w1s_done_i) | wdata_i;
        end
        else
        begin
            w1s_r <= w1s_r & ~w1s_done_i;
        end
    end

    // ------------------------------------------------------------
    // write one to clear event flags; new event wins the clear
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (sreset)
        begin
            w1c_r <= RST_EVT;
        end
        else if (wr_go && rba_hit(addr_i, OFF_W1C))
        begin
            w1c_r <= (w1c_r & ~wdata_i) | evt_w1c_i;
        end
        else
        begin
            w1c_r <= w1c_r | evt_w1c_i;
        end
    end

    // ------------------------------------------------------------
    // write_any_clear flags; data value is ignored
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (sreset)
        begin
            wac_r <= RST_EVT;
        end
        else if (wr_go && rba_hit(addr_i, OFF_WAC))
        begin
            wac_r <= evt_wac_i;
        end
        else
        begin
            wac_r <= wac_r | evt_wac_i;
        end
    end

    // ------------------------------------------------------------
    // self_clearing: one cycle high, readable in that cycle
    // ------------------------------------------------------------
    // a zero write stores nothing new; bits fall next edge anyway
    always_ff @(posedge clock_i)
    begin
        if (sreset)
        begin
            sc_r <= '0;
        end
        else if (wr_go && rba_hit(addr_i, OFF_SCL))
        begin
            sc_r <= wdata_i;
        end
        else
        begin
            sc_r <= '0;
        end
    end

    // ------------------------------------------------------------
    // latch cells and sticky status
    // ------------------------------------------------------------
    rba_latch #(.W(W), .HIGH(1'b0)) u_ll (.clock_i(clock_i), .rst_i(sreset), .src_i(ll_src_i),
        .rd_clr_i(rd_go && rba_hit(addr_i, OFF_LLO)), .val_o(ll_val));
    rba_latch #(.W(W), .HIGH(1'b1)) u_lh (.clock_i(clock_i), .rst_i(sreset), .src_i(lh_src_i),
        .rd_clr_i(rd_go && rba_hit(addr_i, OFF_LHI)), .val_o(lh_val));
    rba_sticky #(.W(W)) u_stk (.clock_i(clock_i), .rst_i(sreset), .cond_i(cond_i),
        .rd_i(rd_go && rba_hit(addr_i, OFF_STK)), .val_o(stk_val));

    // ------------------------------------------------------------
    // read mux; reserved and write-only slots return zero
    // ------------------------------------------------------------
    always_comb
    begin
        case (addr_i)
            OFF_CONFIG: rd_nxt = config_r;
            OFF_KEEP: rd_nxt = keep_r;
            OFF_STATUS: rd_nxt = status_i;
            OFF_SOR: rd_nxt = sor_r;
            OFF_CMD: rd_nxt = RD_UNMAPPED;
            OFF_W1S: rd_nxt = w1s_r;
            OFF_W1C: rd_nxt = w1c_r;
            OFF_WAC: rd_nxt = wac_r;
            OFF_LLO: rd_nxt = ll_val;
            OFF_LHI: rd_nxt = lh_val;
            OFF_SCL: rd_nxt = sc_r;
            OFF_STK: rd_nxt = stk_val;
            default: rd_nxt = RD_UNMAPPED;
        endcase
    end

    // read data captured before the side effect lands
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= rd_go;
            if (rd_go)
            begin
                rdata_r <= rd_nxt;
            end
        end
    end

    assign rdata_o = rdata_r;
    assign rvalid_o = rvalid_r;
    assign config_o = config_r;
    assign keep_o = keep_r;
    assign sor_o = sor_r;
    assign cmd_o = cmd_r;
    assign w1s_o = w1s_r;
    assign w1c_o = w1c_r;
    assign wac_o = wac_r;
    assign sc_o = sc_r;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_ro_read;
        (rd_go && addr_i == OFF_STATUS) |=> rvalid_o && rdata_o == $past(status_i);
    endproperty
    a_ro_read: assert property (p_ro_read) else $error("status read wrong");
    property p_sor;
        (rd_go && addr_i == OFF_SOR && !soft_rst_i) |=> sor_r == '1 && rdata_o == $past(sor_r);
    endproperty
    a_sor: assert property (p_sor) else $error("set on read failed");
    property p_cmd;
        (wr_go && addr_i == OFF_CMD && !soft_rst_i) |=> cmd_o == $past(wdata_i);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command not taken");
    property p_w1s;
        (wr_go && addr_i == OFF_W1S && !soft_rst_i) |=>
            (w1s_r & $past(wdata_i)) == $past(wdata_i) &&
            ((w1s_r ^ $past(w1s_r)) & ~$past(wdata_i) & ~$past(w1s_done_i)) == '0;
    endproperty
    a_w1s: assert property (p_w1s) else $error("write one set wrong");
    property p_w1c;
        (wr_go && addr_i == OFF_W1C && !soft_rst_i && evt_w1c_i == '0) |=>
            (w1c_r & $past(wdata_i)) == '0 && (w1c_r | $past(wdata_i)) == ($past(w1c_r) | $past(wdata_i));
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one clear wrong");
    property p_wac;
        (wr_go && addr_i == OFF_WAC && evt_wac_i == '0) |=> wac_r == '0;
    endproperty
    a_wac: assert property (p_wac) else $error("write any clear failed");
    property p_lh_hold;
        !(rd_go && addr_i == OFF_LHI) && !soft_rst_i |=> ($past(lh_val) & ~lh_val) == '0;
    endproperty
    a_lh_hold: assert property (p_lh_hold) else $error("latch high lost");
    property p_ll_hold;
        !(rd_go && addr_i == OFF_LLO) && !soft_rst_i |=> (~$past(ll_val) & ll_val) == '0;
    endproperty
    a_ll_hold: assert property (p_ll_hold) else $error("latch low lost");
    // only a second write to this register may keep the bits up
    property p_sc;
        (wr_go && addr_i == OFF_SCL && !soft_rst_i) |=> sc_r == $past(wdata_i) ##1
            (sc_r == '0 || ($past(wr_go) && $past(addr_i) == OFF_SCL));
    endproperty
    a_sc: assert property (p_sc) else $error("self clear stuck");
    property p_stk;
        (rd_go && addr_i == OFF_STK && !soft_rst_i) |=> stk_val == $past(cond_i);
    endproperty
    a_stk: assert property (p_stk) else $error("sticky release wrong");
    property p_soft;
        soft_rst_i |=> keep_r == $past(keep_r) && config_r == RST_CONFIG && wac_r == RST_EVT;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset wrong");
    c_sor: cover property (rd_go && addr_i == OFF_SOR ##1 rd_go && addr_i == OFF_SOR);
    c_stk: cover property (cond_i != '0 ##1 cond_i == '0 ##2 rd_go && addr_i == OFF_STK);
    c_w1c: cover property (evt_w1c_i != '0 && wr_go && addr_i == OFF_W1C);
    c_soft: cover property (keep_r != RST_KEEP ##1 soft_rst_i);
endmodule : rba_bank

// File: verif/test_register_bit_access_semantics.sv
// self-checking bench for the register bit access bank
// assumes rba_bank ports as declared in src, one clock, strobes driven at negedge
`timescale 1ns/1ps
module test_register_bit_access_semantics;
    import rba_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock_i;                  // 50 MHz bench clock
    logic rst_i;                    // power-on reset
    logic soft_rst_i;               // software reset
    logic [AW-1:0] addr_i;          // register index
    logic wr_i;                     // write strobe
    logic rd_i;                     // read strobe
    logic [DW-1:0] wdata_i;         // write data
    logic [DW-1:0] rdata_o;         // read data
    logic rvalid_o;                 // read data valid
    logic [DW-1:0] status_i;        // live read-only source
    logic [DW-1:0] w1s_done_i;      // hardware clear of set bits
    logic [DW-1:0] evt_w1c_i;       // write-one-clear events
    logic [DW-1:0] evt_wac_i;       // write_any_clear events
    logic [DW-1:0] ll_src_i;        // latch-low source, idles high
    logic [DW-1:0] lh_src_i;        // latch-high source, idles low
    logic [DW-1:0] cond_i;          // sticky cause
    logic [DW-1:0] config_o, keep_o, sor_o, cmd_o, w1s_o, w1c_o, wac_o, sc_o;
    int err_count;                  // mismatches seen
    int n_compared;                 // comparisons made
    logic [DW-1:0] rd_val;          // last read result

    // ------------------------------------------------------------
    // device under test
    // ------------------------------------------------------------
    rba_bank #(.W(DW)) i_dut (
        .clock_i(clock_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .addr_i(addr_i),
        .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .status_i(status_i), .w1s_done_i(w1s_done_i), .evt_w1c_i(evt_w1c_i),
        .evt_wac_i(evt_wac_i), .ll_src_i(ll_src_i), .lh_src_i(lh_src_i), .cond_i(cond_i),
        .config_o(config_o), .keep_o(keep_o), .sor_o(sor_o), .cmd_o(cmd_o),
        .w1s_o(w1s_o), .w1c_o(w1c_o), .wac_o(wac_o), .sc_o(sc_o)
    );

    // clock: 20 ns period
    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    // compare and count; four-state equality so an x in got matches only an x in exp
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one write cycle; effect is visible at the following negedge
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(negedge clock_i);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge clock_i);
        wr_i = 1'b0;
        wdata_i = 8'h00;
    endtask : wr

    // one read cycle; rvalid_o must stand in the next cycle
    task automatic rd(input logic [AW-1:0] a);
        @(negedge clock_i);
        addr_i = a;
        rd_i = 1'b1;
        @(negedge clock_i);
        rd_i = 1'b0;
        chk({7'h00, rvalid_o}, 8'h01);
        rd_val = rdata_o;
    endtask : rd

    // hold the current input pattern for n cycles
    task automatic idle(input int n);
        repeat (n) @(negedge clock_i);
    endtask : idle

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_ro;
        chk(config_o | keep_o | sor_o | cmd_o | w1s_o | w1c_o | wac_o | sc_o, 8'h00);
        status_i = 8'hA5;
        rd(OFF_STATUS);
        chk(rd_val, 8'hA5);
        wr(OFF_STATUS, 8'hFF);
        status_i = 8'h3C;
        rd(OFF_STATUS);
        chk(rd_val, 8'h3C);
        wr(4'hD, 8'h00);
        rd(4'hD);
        $display("test reset_and_ro done");
    endtask : t_reset_and_ro

    task automatic t_set_on_read;
        wr(OFF_SOR, 8'h12);
        chk(sor_o, 8'h12);
        rd(OFF_SOR);
        chk(rd_val, 8'h12);
        chk(sor_o, 8'hFF);
        wr(OFF_SOR, 8'h21);
        idle(3);
        chk(sor_o, 8'h21);
        // read clashing with a write: write wins, no read side effect
        @(negedge clock_i);
        addr_i = OFF_SOR;
        wdata_i = 8'h5C;
        wr_i = 1'b1;
        rd_i = 1'b1;
        @(negedge clock_i);
        wr_i = 1'b0;
        rd_i = 1'b0;
        wdata_i = 8'h00;
        chk({7'h00, rvalid_o}, 8'h00);
        chk(sor_o, 8'h5C);
        $display("test set_on_read done");
    endtask : t_set_on_read

    task automatic t_write_only;
        wr(OFF_CMD, 8'h5A);
        chk(cmd_o, 8'h5A);
        rd(OFF_CMD);
        wr(OFF_CMD, 8'hC3);
        chk(cmd_o, 8'hC3);
        $display("test write_only done");
    endtask : t_write_only

    task automatic t_w1s_w1c_wac;
        wr(OFF_W1S, 8'h0F);
        chk(w1s_o, 8'h0F);
        wr(OFF_W1S, 8'h00);
        chk(w1s_o, 8'h0F);
        wr(OFF_W1S, 8'hF0);
        chk(w1s_o, 8'hFF);
        w1s_done_i = 8'h03;
        idle(1);
        w1s_done_i = 8'h00;
        chk(w1s_o, 8'hFC);
        evt_w1c_i = 8'hFF;
        evt_wac_i = 8'hFF;
        idle(1);
        evt_w1c_i = 8'h00;
        evt_wac_i = 8'h00;
        chk(w1c_o, 8'hFF);
        chk(wac_o, 8'hFF);
        wr(OFF_W1C, 8'h0F);
        chk(w1c_o, 8'hF0);
        wr(OFF_W1C, 8'h00);
        chk(w1c_o, 8'hF0);
        wr(OFF_WAC, 8'h00);
        chk(wac_o, 8'h00);
        $display("test w1s_w1c_wac done");
    endtask : t_w1s_w1c_wac

    task automatic t_latches;
        lh_src_i = 8'h01;
        ll_src_i = 8'hFE;
        idle(1);
        lh_src_i = 8'h00;
        ll_src_i = 8'hFF;
        idle(4);
        rd(OFF_LHI);
        chk(rd_val, 8'h01);
        rd(OFF_LHI);
        chk(rd_val, 8'h00);
        rd(OFF_LLO);
        chk(rd_val, 8'hFE);
        rd(OFF_LLO);
        chk(rd_val, 8'hFF);
        $display("test latches done");
    endtask : t_latches

    task automatic t_self_clear;
        wr(OFF_SCL, 8'h81);
        chk(sc_o, 8'h81);
        idle(1);
        chk(sc_o, 8'h00);
        wr(OFF_SCL, 8'h00);
        chk(sc_o, 8'h00);
        $display("test self_clear done");
    endtask : t_self_clear

    task automatic t_sticky;
        cond_i = 8'h04;
        idle(1);
        cond_i = 8'h00;
        idle(4);
        rd(OFF_STK);
        chk(rd_val, 8'h04);
        rd(OFF_STK);
        chk(rd_val, 8'h00);
        cond_i = 8'h08;
        idle(2);
        rd(OFF_STK);
        chk(rd_val, 8'h08);
        rd(OFF_STK);
        chk(rd_val, 8'h08);
        cond_i = 8'h00;
        idle(2);
        rd(OFF_STK);
        chk(rd_val, 8'h00);
        $display("test sticky done");
    endtask : t_sticky

    task automatic t_soft_reset;
        wr(OFF_CONFIG, 8'h33);
        wr(OFF_KEEP, 8'h44);
        wr(OFF_W1S, 8'h81);
        @(negedge clock_i);
        soft_rst_i = 1'b1;
        @(negedge clock_i);
        soft_rst_i = 1'b0;
        chk(keep_o, 8'h44);
        chk(config_o, 8'h00);
        chk(w1s_o, 8'h00);
        $display("test soft_reset done");
    endtask : t_soft_reset

    // ------------------------------------------------------------
    // verdict
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // watchdog: the run needs under a hundred cycles, allow 5000
    initial
    begin
        #(5000 * 20);
        err_count++;
        stop_test();
    end

    // main sequence
    initial
    begin
        err_count = 0;
        n_compared = 0;
        rst_i = 1'b1;
        soft_rst_i = 1'b0;
        addr_i = 4'h0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        wdata_i = 8'h00;
        status_i = 8'h00;
        w1s_done_i = 8'h00;
        evt_w1c_i = 8'h00;
        evt_wac_i = 8'h00;
        ll_src_i = 8'hFF;
        lh_src_i = 8'h00;
        cond_i = 8'h00;
        rd_val = 8'h00;
        repeat (5) @(negedge clock_i);
        rst_i = 1'b0;
        t_reset_and_ro();
        t_set_on_read();
        t_write_only();
        t_w1s_w1c_wac();
        t_latches();
        t_self_clear();
        t_sticky();
        t_soft_reset();
        stop_test();
    end

endmodule : test_register_bit_access_semantics
